// [hw/pnp_cfg.v]
/*
 * Plug-and-play configuration front end: initiation key checker,
 * card state machine, configuration register access through the
 * address, write and read ports, and serial isolation.
 * Assumes ISA strobes are single-cycle pulses synchronous to CLK,
 * one per I/O cycle, with the address and write data valid with them.
 */
`timescale 1ns/1ps
`include "pnp_cfg_defs.vh"

module pnp_cfg
#(
    // Identifier value is arbitrary; top byte 8'h5a is not its checksum, which is 8'hb0
    parameter [71:0] SERIAL_ID = 72'h5a_0000_0001_1234_5678
)
(
    // Clock and reset
    input  wire        CLK,
    input  wire        RSTN,
    input  wire        CE,
    // ISA I/O cycle
    input  wire [11:0] SA,
    input  wire        IOW_STB,
    input  wire        IOR_STB,
    input  wire [7:0]  SD_IN,
    output reg  [7:0]  SD_OUT,
    output wire        SD_OE_N,
    // Card state to the rest of the controller
    output wire        CONFIG_MODE,
    output wire        CARD_ACTIVE,
    output wire        DEV_RESET,
    output wire [7:0]  CARD_SELECT_NUMBER
);

// ----------------------------------------------------------------
// Card states
// ----------------------------------------------------------------
localparam [1:0] ST_WAIT_KEY = 2'd0;
localparam [1:0] ST_SLEEP    = 2'd1;
localparam [1:0] ST_ISOLATE  = 2'd2;
localparam [1:0] ST_CONFIG   = 2'd3;

localparam [255:0] KEY = `INIT_KEY;

reg  [1:0]  state_q;
reg  [1:0]  state_d;
reg  [4:0]  key_idx_q;
reg  [7:0]  addr_q;
reg  [7:0]  rd_port_q;
reg  [7:0]  card_select_number_q;
reg  [6:0]  bit_idx_q;
reg         second_q;
reg         drove_q;
reg         sensed_q;
reg         lost_q;
reg         dev_reset_q;
reg         oe_q;

wire [7:0]  key_byte;
wire        addr_wr;
wire        data_wr;
wire        data_rd;
wire        cur_bit;
wire        in_cfg;
wire [11:0] rd_addr;
wire        id_nonzero;
wire        iso_drive;
wire [7:0]  key_rom [0:31];

// ----------------------------------------------------------------
// Decode
// ----------------------------------------------------------------
assign rd_addr  = {`RD_PORT_HI, rd_port_q, `RD_PORT_LO};
assign addr_wr  = IOW_STB && (SA == `ADDR_PORT);
assign in_cfg   = (state_q != ST_WAIT_KEY);
assign data_wr  = IOW_STB && (SA == `WDATA_PORT) && in_cfg;
assign data_rd  = IOR_STB && (SA == rd_addr) && in_cfg
                  && (state_q == ST_ISOLATE || state_q == ST_CONFIG);
assign key_byte = key_rom[key_idx_q];
// Byte (bit_idx/8) of the identifier, bit (bit_idx%8) in it
assign cur_bit  = SERIAL_ID[bit_idx_q];
// An all-zero identifier never joins isolation
assign id_nonzero = |SERIAL_ID;
// This card drives the current isolation read
assign iso_drive  = state_q == ST_ISOLATE && !lost_q && (second_q ? drove_q : cur_bit);

assign CONFIG_MODE        = in_cfg;
assign CARD_ACTIVE        = 1'b0;
assign DEV_RESET          = dev_reset_q;
assign CARD_SELECT_NUMBER = card_select_number_q;
assign SD_OE_N            = ~oe_q;

// ----------------------------------------------------------------
// Key table, one byte per entry, first byte at entry 0
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < 32; g = g + 1)
    begin : key_tab
        assign key_rom[g] = KEY[255 - 8 * g -: 8];
    end
endgenerate

// ----------------------------------------------------------------
// Next card state
// ----------------------------------------------------------------
always @*
begin
    state_d = state_q;
    if (state_q == ST_WAIT_KEY)
    begin
        if (addr_wr && SD_IN == key_byte && key_idx_q == `KEY_LEN)
            state_d = ST_SLEEP;
    end
    else if (data_wr && addr_q == `REG_CFG_CTRL && SD_IN[`CTRL_WFK_BIT])
    begin
        state_d = ST_WAIT_KEY;
    end
    else if (data_wr && addr_q == `REG_CFG_CTRL && SD_IN[`CTRL_RESET_BIT])
    begin
        state_d = ST_WAIT_KEY;
    end
    else if (data_wr && addr_q == `REG_WAKE)
    begin
        if (SD_IN == card_select_number_q)
        begin
            if (SD_IN == `CSN_RST)
            begin
                if (id_nonzero)
                    state_d = ST_ISOLATE;
                else
                    state_d = ST_SLEEP;
            end
            else
            begin
                state_d = ST_CONFIG;
            end
        end
        else
        begin
            state_d = ST_SLEEP;
        end
    end
    else if (state_q == ST_ISOLATE && data_wr && addr_q == `REG_CSN)
    begin
        state_d = ST_CONFIG;
    end
    else if (state_q == ST_ISOLATE && lost_q)
    begin
        state_d = ST_SLEEP;
    end
end

// ----------------------------------------------------------------
// Key checker and card state
// ----------------------------------------------------------------
always @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        state_q   <= ST_WAIT_KEY;
        key_idx_q <= 5'd0;
    end
    else if (CE)
    begin
        state_q <= state_d;
        if (state_q != ST_WAIT_KEY)
        begin
            key_idx_q <= 5'd0;
        end
        else if (addr_wr)
        begin
            if (SD_IN == key_byte)
                key_idx_q <= key_idx_q + 5'd1;
            else if (SD_IN == key_rom[0])
                key_idx_q <= 5'd1;
            else
                key_idx_q <= 5'd0;
        end
        else if ((IOW_STB || IOR_STB) && SA == `ADDR_PORT)
        begin
            key_idx_q <= 5'd0;
        end
    end
end

// ----------------------------------------------------------------
// Address register, read port, card select number
// ----------------------------------------------------------------
always @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        addr_q               <= 8'h00;
        rd_port_q            <= `RD_PORT_RST;
        card_select_number_q <= `CSN_RST;
        dev_reset_q          <= 1'b0;
    end
    else if (CE)
    begin
        dev_reset_q <= 1'b0;
        if (addr_wr && in_cfg)
            addr_q <= SD_IN;
        if (data_wr)
        begin
            if (addr_q == `REG_SET_RD)
            begin
                // Only cards in isolation or config may relocate
                if (state_q == ST_ISOLATE || state_q == ST_CONFIG)
                    rd_port_q <= SD_IN;
            end
            else if (addr_q == `REG_CFG_CTRL)
            begin
                if (SD_IN[`CTRL_CSN_BIT] || SD_IN[`CTRL_RESET_BIT])
                    card_select_number_q <= `CSN_RST;
                if (SD_IN[`CTRL_RESET_BIT])
                    dev_reset_q <= 1'b1;
            end
            else if (addr_q == `REG_CSN)
            begin
                if (state_q == ST_ISOLATE || state_q == ST_CONFIG)
                    card_select_number_q <= SD_IN;
            end
        end
    end
end

// ----------------------------------------------------------------
// Serial isolation
// ----------------------------------------------------------------
always @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        bit_idx_q <= 7'd0;
        second_q  <= 1'b0;
        drove_q   <= 1'b0;
        sensed_q  <= 1'b0;
        lost_q    <= 1'b0;
    end
    else if (CE)
    begin
        lost_q <= 1'b0;
        if (state_q != ST_ISOLATE)
        begin
            bit_idx_q <= 7'd0;
            second_q  <= 1'b0;
            drove_q   <= 1'b0;
            sensed_q  <= 1'b0;
        end
        else if (data_rd && addr_q == `REG_ISOLATE && !lost_q)
        begin
            if (!second_q)
            begin
                drove_q  <= cur_bit;
                sensed_q <= !cur_bit && SD_IN[1:0] == `ISO_SENSE1;
                second_q <= 1'b1;
            end
            else
            begin
                second_q <= 1'b0;
                if (!drove_q && sensed_q && SD_IN[1:0] == `ISO_SENSE2)
                begin
                    lost_q <= 1'b1;
                end
                else if (bit_idx_q != `SERIAL_BITS - 7'd1)
                begin
                    bit_idx_q <= bit_idx_q + 7'd1;
                end
            end
        end
    end
end

// ----------------------------------------------------------------
// Read data
// ----------------------------------------------------------------
always @(posedge CLK or negedge RSTN)
begin
    if (!RSTN)
    begin
        SD_OUT <= 8'h00;
        oe_q   <= 1'b0;
    end
    else if (CE)
    begin
        oe_q <= 1'b0;
        if (data_rd)
        begin
            oe_q <= 1'b1;
            if (addr_q == `REG_ISOLATE)
            begin
                if (iso_drive)
                    SD_OUT <= second_q ? `ISO_DRIVE2 : `ISO_DRIVE1;
                else
                    oe_q <= 1'b0;
            end
            else if (addr_q == `REG_CSN)
                SD_OUT <= card_select_number_q;
            else if (addr_q == `REG_LDN)
                SD_OUT <= `LDN_VALUE;
            else if (addr_q == `REG_STATUS)
                SD_OUT <= 8'h00;
            else
                oe_q <= 1'b0;
        end
    end
end

endmodule

// [hw/pnp_cfg_defs.vh]
/*
 * Constants for the plug-and-play configuration front end: port
 * addresses, register indices, control bits, isolation constants and the initiation key.
 * Assumes a 12-bit ISA I/O address and an 8-bit data bus.
 */
`ifndef PNP_CFG_DEFS_VH
`define PNP_CFG_DEFS_VH

// ----------------------------------------------------------------
// Port decode
// ----------------------------------------------------------------
`define ADDR_PORT        12'h279
`define WDATA_PORT       12'ha79
`define RD_PORT_LO       2'h3
`define RD_PORT_HI       2'h0
`define RD_PORT_RST      8'h00

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define REG_SET_RD       8'h00
`define REG_ISOLATE      8'h01
`define REG_CFG_CTRL     8'h02
`define REG_WAKE         8'h03
`define REG_RES_DATA     8'h04
`define REG_STATUS       8'h05
`define REG_CSN          8'h06
`define REG_LDN          8'h07

// ----------------------------------------------------------------
// Config control bits
// ----------------------------------------------------------------
`define CTRL_RESET_BIT   0
`define CTRL_WFK_BIT     1
`define CTRL_CSN_BIT     2

// ----------------------------------------------------------------
// Isolation, key length, card select number reset and logical device number
// ----------------------------------------------------------------
`define ISO_DRIVE1       8'h55
`define ISO_DRIVE2       8'haa
`define ISO_SENSE1       2'h1
`define ISO_SENSE2       2'h2
`define SERIAL_BITS      7'd72
`define KEY_LEN          5'd31
`define CSN_RST          8'h00
`define LDN_VALUE        8'h00

// ----------------------------------------------------------------
// Initiation key, 32 bytes packed first byte in the top bits
// ----------------------------------------------------------------
`define INIT_KEY {8'h6a, 8'hb5, 8'hda, 8'hed, 8'hf6, 8'hfb, 8'h7d, 8'hbe, \
                  8'hdf, 8'h6f, 8'h37, 8'h1b, 8'h0d, 8'h86, 8'hc3, 8'h61, \
                  8'hb0, 8'h58, 8'h2c, 8'h16, 8'h8b, 8'h45, 8'ha2, 8'hd1, \
                  8'he8, 8'h74, 8'h3a, 8'h9d, 8'hce, 8'he7, 8'h73, 8'h39}

`endif

// [verification/isa_pnp_isolation_config_tb_top.sv]
/* Self-checking bench for pnp_cfg with a competing card model.
   Assumes the design header is on the include path. */
`timescale 1ns/1ps
`include "pnp_cfg_defs.vh"
module isa_pnp_isolation_config_tb_top;
    localparam [63:0]  SID_LO = 64'h0000_0001_1234_5678;
    localparam [71:0]  SID = {csum(SID_LO), SID_LO};
    localparam [255:0] KEY = `INIT_KEY;
    localparam [8:0]   NONE = 9'h100;
    reg        CLK = 0, RSTN = 0, IOW_STB = 0, IOR_STB = 0, peer_en = 0, rd_q = 0;
    reg [11:0] SA = 12'h000;
    reg [7:0]  tb_sd = 8'h00, card_select_number;
    reg        CE = 1;
    reg [71:0] rx = 72'h0;
    wire [7:0] SD_OUT, CARD_SELECT_NUMBER, drv;
    wire       SD_OE_N, CONFIG_MODE, CARD_ACTIVE, DEV_RESET, drv_oe_n;
    wire [7:0] sd_bus = drv_oe_n ? tb_sd : drv;
    int        bad_count = 0, checks = 0;
    logic [8:0] q[$];
    always #50 CLK = ~CLK;
    pnp_cfg #(.SERIAL_ID(SID)) u_dut (.CLK(CLK), .RSTN(RSTN), .CE(CE), .SA(SA),
        .IOW_STB(IOW_STB), .IOR_STB(IOR_STB), .SD_IN(sd_bus), .SD_OUT(SD_OUT),
        .SD_OE_N(SD_OE_N), .CONFIG_MODE(CONFIG_MODE), .CARD_ACTIVE(CARD_ACTIVE),
        .DEV_RESET(DEV_RESET), .CARD_SELECT_NUMBER(CARD_SELECT_NUMBER));
    iso_peer u_peer (.clk(CLK), .rstn(RSTN), .en(peer_en), .sa(SA), .ior(IOR_STB),
        .id(~SID), .drv(drv), .drv_oe_n(drv_oe_n));
    // ----------------
    // Tasks
    // ----------------
    // Host checksum: the key's own shift register fed with each identifier bit
    function [7:0] csum(input [63:0] v);
        reg [7:0] c;
        begin
            c = 8'h6a;
            for (int k = 0; k < 64; k++)
                c = {c[0] ^ c[1] ^ v[k], c[7:1]};
            csum = c;
        end
    endfunction
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task io(input bit w, input [11:0] a, input [7:0] d, input logic [8:0] e);
        if (!w)
            q.push_back(e);
        @(posedge CLK);
        #10 SA = a;
        tb_sd = w ? d : ~tb_sd;
        IOW_STB = w;
        IOR_STB = !w;
        @(posedge CLK);
        #10 IOW_STB = 0;
        IOR_STB = 0;
    endtask
    task wreg(input [7:0] i, input [7:0] d);
        io(1, 12'h279, i, 9'h000);
        io(1, 12'ha79, d, 9'h000);
    endtask
    task key(input int bad);
        for (int i = 0; i < 32; i++)
            io(1, 12'h279, i == bad ? 8'h00 : KEY[255-8*i -: 8], 9'h000);
    endtask
    // Shortened pair gap keeps the run short; the card keeps no timing
    task iso(input int n, input bit comp, input bit alive);
        bit b;
        logic [8:0] p1;
        for (int i = 0; i < n; i++)
        begin
            b = SID[i] && alive;
            io(0, 12'h203, 8'h00, b ? 9'h055 : NONE);
            p1 = {SD_OE_N, SD_OUT};
            io(0, 12'h203, 8'h00, b ? 9'h0aa : NONE);
            rx[i] = p1 == 9'h055 && {SD_OE_N, SD_OUT} == 9'h0aa;
            if (alive && !SID[i] && comp && !SID[i] == 1'b1)
                alive = 0;
            repeat (8) @(posedge CLK);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------
    // Checking and stimulus
    // ----------------
    always @(negedge CLK)
    begin
        if (rd_q)
            chk({SD_OE_N, SD_OE_N ? 8'h00 : SD_OUT}, q.pop_front());
        rd_q = IOR_STB;
    end
    initial
    begin
        #4_000_000;
        bad_count++;
        end_sim;
    end
    initial
    begin
        repeat (12) @(posedge CLK);
        #10 RSTN = 1;
        io(0, 12'h003, 8'h00, NONE);
        wreg(8'h03, 8'h00);
        chk({7'h00, CARD_ACTIVE, CONFIG_MODE}, 9'h000);
        $display("test idle done");
        CE = 0;
        key(-1);
        CE = 1;
        chk({8'h00, CONFIG_MODE}, 9'h000);
        key(10);
        chk({8'h00, CONFIG_MODE}, 9'h000);
        key(-1);
        chk({8'h00, CONFIG_MODE}, 9'h001);
        $display("test key done");
        wreg(8'h03, 8'h00);
        wreg(8'h00, 8'h80);
        wreg(8'h01, 8'h00);
        repeat (10000) @(posedge CLK);
        iso(72, 0, 1);
        chk({1'b0, rx[71:64]}, {1'b0, csum(rx[63:0])});
        chk({1'b0, rx[7:0]}, {1'b0, SID[7:0]});
        card_select_number = lfsr(8'h57) | 8'h01;
        wreg(8'h06, card_select_number);
        chk({1'b0, CARD_SELECT_NUMBER}, {1'b0, card_select_number});
        io(0, 12'h203, 8'h00, {1'b0, card_select_number});
        $display("test isolation done");
        wreg(8'h02, 8'h02);
        chk({CONFIG_MODE, CARD_SELECT_NUMBER}, {1'b0, card_select_number});
        key(-1);
        wreg(8'h03, 8'h00);
        wreg(8'h01, 8'h00);
        iso(2, 0, 0);
        wreg(8'h02, 8'h04);
        chk({1'b0, CARD_SELECT_NUMBER}, 9'h000);
        wreg(8'h03, 8'h00);
        wreg(8'h01, 8'h00);
        repeat (10000) @(posedge CLK);
        peer_en = 1;
        iso(4, 1, 1);
        peer_en = 0;
        wreg(8'h02, 8'h01);
        chk({DEV_RESET, CONFIG_MODE, 7'h00}, 9'h100);
        chk({1'b0, CARD_SELECT_NUMBER}, 9'h000);
        $display("test contention done");
        @(posedge CLK);
        #10 RSTN = 0;
        repeat (2) @(posedge CLK);
        #10 RSTN = 1;
        chk({CONFIG_MODE, CARD_SELECT_NUMBER}, 9'h000);
        $display("test reset done");
        repeat (4) @(posedge CLK);
        end_sim;
    end
endmodule

// [verification/iso_peer.sv]
/* A competing card on the isolation reads; never loses itself.
   Assumes reads are one-cycle strobes at read port address RD. */
`timescale 1ns/1ps
module iso_peer
#(
    parameter [11:0] RD = 12'h203
)
(
    input  wire        clk,
    input  wire        rstn,
    input  wire        en,
    input  wire [11:0] sa,
    input  wire        ior,
    input  wire [71:0] id,
    output wire [7:0]  drv,
    output wire        drv_oe_n
);
    reg [6:0] idx_q;
    reg       ph_q;
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn || !en)
        begin
            idx_q <= 7'h00;
            ph_q  <= 1'b0;
        end
        else if (ior && sa == RD)
        begin
            ph_q <= ~ph_q;
            if (ph_q)
                idx_q <= idx_q + 7'h01;
        end
    end
    assign drv_oe_n = !(en && ior && sa == RD && id[idx_q]);
    assign drv      = ph_q ? 8'haa : 8'h55;
endmodule

// [verification/pnp_cfg_sva.sv]
/* Port checker for the plug-and-play configuration front end.
   Assumes one CLK domain with RSTN active low, bound onto pnp_cfg. */
`timescale 1ns/1ps
module pnp_cfg_sva
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        CE,
    // ISA cycle
    input wire logic [11:0] SA,
    input wire logic        IOW_STB,
    input wire logic        IOR_STB,
    input wire logic [7:0]  SD_IN,
    input wire logic [7:0]  SD_OUT,
    input wire logic        SD_OE_N,
    // Card state
    input wire logic        CONFIG_MODE,
    input wire logic        CARD_ACTIVE,
    input wire logic        DEV_RESET,
    input wire logic [7:0]  CARD_SELECT_NUMBER
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // ----------------
    // Assertions
    // ----------------
    drive_cause_a: assert property (!SD_OE_N |-> $past(IOR_STB && CE))
        else $error("data driven without a read");
    wfk_silent_a: assert property ($past(!CONFIG_MODE) |-> SD_OE_N)
        else $error("data driven while waiting for key");
    card_inactive_a: assert property (!CARD_ACTIVE)
        else $error("card active");
    key_entry_a: assert property ($rose(CONFIG_MODE) |->
        $past(IOW_STB && CE && SA == 12'h279 && SD_IN == 8'h39))
        else $error("config mode without final key byte");
    dev_reset_a: assert property (DEV_RESET |->
        $past(IOW_STB && CE && SA == 12'ha79 && SD_IN[0]))
        else $error("device reset without command");
    csn_write_a: assert property (CARD_SELECT_NUMBER != $past(CARD_SELECT_NUMBER) |->
        $past(IOW_STB && CE && SA == 12'ha79))
        else $error("card number changed without write");
    cfg_exit_a: assert property ($fell(CONFIG_MODE) |->
        $past(IOW_STB && CE && SA == 12'ha79))
        else $error("left config mode without command");
    write_only_a: assert property ($past(IOR_STB && (SA == 12'h279 || SA == 12'ha79))
        |-> SD_OE_N)
        else $error("write-only port answered a read");
    cover property ($rose(CONFIG_MODE));
    cover property (!SD_OE_N && SD_OUT == 8'haa);
    cover property (DEV_RESET);
endmodule
bind pnp_cfg pnp_cfg_sva u_sva (.CLK(CLK), .RSTN(RSTN), .CE(CE), .SA(SA), .IOW_STB(IOW_STB),
    .IOR_STB(IOR_STB), .SD_IN(SD_IN), .SD_OUT(SD_OUT), .SD_OE_N(SD_OE_N),
    .CONFIG_MODE(CONFIG_MODE), .CARD_ACTIVE(CARD_ACTIVE), .DEV_RESET(DEV_RESET),
    .CARD_SELECT_NUMBER(CARD_SELECT_NUMBER));
